/* pkg/sfas_pkg.sv */
// constants, types and decode functions of the serial flash access sequencer
// Functional notes
// - fast read, page program, sector erase: opcode then three address bytes; read adds dummy
// - opcode 0x05 reads status, 0x06 write enable, 0xc7 chip erase, single byte
// - status write is opcode 0x01 plus exactly one status byte, never a second
// - read and program data bytes run back to back while select stays low
// - no identification read is ever issued; protocol and rate stay as configured
// - flash hold and write-protect inputs are never driven, left to board pull-ups
// - while system reset low is held, clock, data and flash select float
// - driver select stays driven during reset, never floated
// - host requests programming; the sequencer issues all needed flash commands itself
// - clock and data shared by two slaves, each with its own select
// - serial clock runs at most 20 MHz (100 MHz source over divisor 5) toward both slaves
// - host control port runs at 100 kHz, pace set by slowest device
// - single-bit SPI mode 0: clock idles low, data sampled on rising edge
// - serial clock is source clock divided by integer divisor 5 to 127
// - before program or erase: write enable, poll status until latch set
// - boot and flash traffic always use select zero, the flash select
package sfas_pkg;

  // ---------------------------------------------------------------
  // flash opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_FAST_READ = 8'h0b;
  localparam logic [7:0] OPC_PAGE_PROG = 8'h02;
  localparam logic [7:0] OPC_SECT_ERASE = 8'h20;
  localparam logic [7:0] OPC_STATUS_READ = 8'h05;
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OPC_FILL = 8'h00;

  // ---------------------------------------------------------------
  // fields, sizes and timing
  // ---------------------------------------------------------------
  localparam int LATCH_POS = 1;
  localparam int ADDR_W = 24;
  localparam int LEN_W = 16;
  localparam int DIV_W = 7;
  localparam logic [6:0] DIV_MIN = 7'h05;
  localparam logic [6:0] DIV_MAX = 7'h7f;
  localparam logic [2:0] HDR_ADDR = 3'h4;
  localparam logic [2:0] HDR_READ = 3'h5;
  localparam logic [2:0] HDR_OPC = 3'h1;
  localparam logic [2:0] HDR_NONE = 3'h0;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DESELECT_NS = 200;
  localparam int DESELECT_CYC = (DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] GAP_LAST = 5'(DESELECT_CYC - 1);

  // ---------------------------------------------------------------
  // commands and states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ = 3'b000,
    OP_PROG = 3'b001,
    OP_SECT_ERASE = 3'b010,
    OP_CHIP_ERASE = 3'b011,
    OP_STATUS_READ = 3'b100,
    OP_STATUS_WRITE = 3'b101,
    OP_DRV_WRITE = 3'b110
  } sfas_op_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ENABLE = 3'b001,
    S_POLL = 3'b010,
    S_MAIN = 3'b011,
    S_GAP = 3'b100,
    S_DONE = 3'b101
  } sfas_state_e;

  // ---------------------------------------------------------------
  // decode functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] sfas_opcode(input sfas_op_e op);
    case (op)
      OP_READ: sfas_opcode = OPC_FAST_READ;
      OP_PROG: sfas_opcode = OPC_PAGE_PROG;
      OP_SECT_ERASE: sfas_opcode = OPC_SECT_ERASE;
      OP_CHIP_ERASE: sfas_opcode = OPC_CHIP_ERASE;
      OP_STATUS_READ: sfas_opcode = OPC_STATUS_READ;
      OP_STATUS_WRITE: sfas_opcode = OPC_STATUS_WRITE;
      default: sfas_opcode = OPC_FILL;
    endcase
  endfunction

  function automatic logic sfas_needs_enable(input sfas_op_e op);
    sfas_needs_enable = (op == OP_PROG) || (op == OP_SECT_ERASE) ||
                      (op == OP_CHIP_ERASE) || (op == OP_STATUS_WRITE);
  endfunction

  function automatic logic [2:0] sfas_hdr_len(input sfas_op_e op);
    case (op)
      OP_READ: sfas_hdr_len = HDR_READ;
      OP_PROG, OP_SECT_ERASE: sfas_hdr_len = HDR_ADDR;
      OP_DRV_WRITE: sfas_hdr_len = HDR_NONE;
      default: sfas_hdr_len = HDR_OPC;
    endcase
  endfunction

endpackage

/* src/sfas_fifo.sv */
// byte fifo between the host write stream and the serial engine
`timescale 1ns/1ps
module sfas_fifo
  import sfas_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic push;
  logic pull;

  // ---------------------------------------------------------------
  // flags
  // ---------------------------------------------------------------
  assign push = in_valid && in_ready;
  assign pull = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pull) begin
      next_count = count + CW'(1);
    end else if (pull && !push) begin
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      count <= next_count;
      in_ready <= (next_count != FULL_CNT);
      out_valid <= (next_count != '0);
    end
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pull) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

/* src/sfas_sequencer.sv */
// serial flash and illumination driver access sequencer
`timescale 1ns/1ps
module sfas_sequencer
  import sfas_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic system_reset_low,
  input wire logic [DIV_W-1:0] clock_divisor,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [LEN_W-1:0] cmd_len,
  input wire logic [7:0] cmd_status,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic serial_port_clock_out,
  output logic serial_port_clock_oe,
  output logic serial_port_data_out,
  output logic serial_port_data_oe,
  input wire logic serial_port_data_in,
  output logic flash_select_low,
  output logic flash_select_oe,
  output logic driver_select_low
);

  sfas_state_e state;
  sfas_state_e ret_state;
  sfas_op_e op;
  logic rst_any;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wstatus;
  logic [LEN_W-1:0] rem;
  logic [2:0] idx;
  logic [2:0] hdr_len;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] half_len;
  logic [DIV_W-1:0] low_len;
  logic [4:0] gap_cnt;
  logic rx_pend;
  logic latch_seen;
  logic go;
  logic [7:0] go_byte;
  logic pop;
  logic eng_busy;
  logic [DIV_W-1:0] eng_cnt;
  logic [2:0] eng_bit;
  logic [7:0] eng_tx;
  logic [7:0] eng_rx;
  logic eng_idle;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic [7:0] hdr_byte;

  assign rst_any = reset || !system_reset_low;
  assign eng_idle = !eng_busy && !go;
  assign half_len = div_q >> 1;
  assign low_len = div_q - half_len;

  always_comb begin
    hdr_byte = OPC_FILL;
    if (idx == 3'h0) begin
      hdr_byte = sfas_opcode(op);
    end else if (idx == 3'h1) begin
      hdr_byte = addr[23:16];
    end else if (idx == 3'h2) begin
      hdr_byte = addr[15:8];
    end else if (idx == 3'h3) begin
      hdr_byte = addr[7:0];
    end
  end

  // ---------------------------------------------------------------
  // write data fifo
  // ---------------------------------------------------------------
  sfas_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  // float port on reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      serial_port_clock_oe <= 1'b0;
      serial_port_data_oe <= 1'b0;
      flash_select_oe <= 1'b0;
    end else begin
      serial_port_clock_oe <= system_reset_low;
      serial_port_data_oe <= system_reset_low;
      flash_select_oe <= system_reset_low;
    end
  end

  // ---------------------------------------------------------------
  // bit engine
  // ---------------------------------------------------------------
  // mode 0 shifting
  always_ff @(posedge ref_clk) begin
    if (rst_any) begin
      eng_busy <= 1'b0;
      eng_cnt <= '0;
      eng_bit <= '0;
      eng_tx <= '0;
      eng_rx <= '0;
      serial_port_clock_out <= 1'b0;
      serial_port_data_out <= 1'b0;
    end else if (go) begin
      eng_busy <= 1'b1;
      eng_cnt <= '0;
      eng_bit <= '0;
      eng_tx <= go_byte;
      serial_port_data_out <= go_byte[7];
    end else if (eng_busy) begin
      eng_cnt <= eng_cnt + DIV_W'(1);
      if (!serial_port_clock_out && eng_cnt == low_len - DIV_W'(1)) begin
        serial_port_clock_out <= 1'b1;
        eng_rx <= {eng_rx[6:0], serial_port_data_in};
        eng_cnt <= '0;
      end else if (serial_port_clock_out && eng_cnt == half_len - DIV_W'(1)) begin
        serial_port_clock_out <= 1'b0;
        eng_cnt <= '0;
        if (eng_bit == 3'h7) begin
          eng_busy <= 1'b0;
        end else begin
          eng_bit <= eng_bit + 3'h1;
          eng_tx <= {eng_tx[6:0], 1'b0};
          serial_port_data_out <= eng_tx[6];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    go <= 1'b0;
    pop <= 1'b0;
    done <= 1'b0;
    rd_valid <= 1'b0;
    if (rst_any) begin
      state <= S_IDLE;
      ret_state <= S_IDLE;
      op <= OP_READ;
      addr <= '0;
      wstatus <= '0;
      rem <= '0;
      idx <= '0;
      hdr_len <= '0;
      div_q <= DIV_MIN;
      gap_cnt <= '0;
      rx_pend <= 1'b0;
      latch_seen <= 1'b0;
      go_byte <= '0;
      rd_data <= '0;
      cmd_ready <= 1'b0;
      flash_select_low <= 1'b1;
      driver_select_low <= 1'b1;
    end else begin
      case (state)
        S_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op <= sfas_op_e'(cmd_op);
            addr <= cmd_addr;
            wstatus <= cmd_status;
            hdr_len <= sfas_hdr_len(sfas_op_e'(cmd_op));
            div_q <= (clock_divisor < DIV_MIN) ? DIV_MIN : clock_divisor;
            idx <= '0;
            latch_seen <= 1'b0;
            rx_pend <= 1'b0;
            if (sfas_op_e'(cmd_op) == OP_READ || sfas_op_e'(cmd_op) == OP_PROG ||
                sfas_op_e'(cmd_op) == OP_DRV_WRITE) begin
              rem <= cmd_len;
            end else if (sfas_op_e'(cmd_op) == OP_STATUS_READ ||
                         sfas_op_e'(cmd_op) == OP_STATUS_WRITE) begin
              rem <= 16'h0001;
            end else begin
              rem <= '0;
            end
            state <= sfas_needs_enable(sfas_op_e'(cmd_op)) ? S_ENABLE : S_MAIN;
          end
        end
        S_ENABLE: begin
          if (eng_idle) begin
            if (idx == 3'h0) begin
              go <= 1'b1;
              go_byte <= OPC_WRITE_ENABLE;
              flash_select_low <= 1'b0;
              idx <= 3'h1;
            end else begin
              flash_select_low <= 1'b1;
              gap_cnt <= '0;
              ret_state <= S_POLL;
              state <= S_GAP;
            end
          end
        end
        S_POLL: begin
          if (eng_idle) begin
            if (idx == 3'h0) begin
              go <= 1'b1;
              go_byte <= OPC_STATUS_READ;
              flash_select_low <= 1'b0;
              idx <= 3'h1;
            end else if (idx == 3'h1) begin
              go <= 1'b1;
              go_byte <= OPC_FILL;
              idx <= 3'h2;
            end else begin
              flash_select_low <= 1'b1;
              gap_cnt <= '0;
              latch_seen <= eng_rx[LATCH_POS];
              ret_state <= eng_rx[LATCH_POS] ? S_MAIN : S_POLL;
              state <= S_GAP;
            end
          end
        end
        S_MAIN: begin
          if (eng_idle) begin
            if (rx_pend) begin
              rd_valid <= 1'b1;
              rd_data <= eng_rx;
              rx_pend <= 1'b0;
            end
            if (idx < hdr_len) begin
              go <= 1'b1;
              go_byte <= hdr_byte;
              idx <= idx + 3'h1;
              flash_select_low <= 1'b0;
            end else if (rem != '0) begin
              if (op == OP_READ || op == OP_STATUS_READ) begin
                go <= 1'b1;
                go_byte <= OPC_FILL;
                rx_pend <= 1'b1;
                rem <= rem - 16'h0001;
              end else if (op == OP_STATUS_WRITE) begin
                go <= 1'b1;
                go_byte <= wstatus;
                rem <= rem - 16'h0001;
              end else if (fifo_valid) begin
                go <= 1'b1;
                go_byte <= fifo_data;
                pop <= 1'b1;
                rem <= rem - 16'h0001;
                if (op == OP_DRV_WRITE) begin
                  driver_select_low <= 1'b0;
                end else begin
                  flash_select_low <= 1'b0;
                end
              end
            end else begin
              flash_select_low <= 1'b1;
              driver_select_low <= 1'b1;
              gap_cnt <= '0;
              ret_state <= S_DONE;
              state <= S_GAP;
            end
          end
        end
        S_GAP: begin
          if (gap_cnt == GAP_LAST) begin
            state <= ret_state;
            idx <= '0;
          end else begin
            gap_cnt <= gap_cnt + 5'h01;
          end
        end
        S_DONE: begin
          done <= 1'b1;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  fast_read_opc_a: assert property (
    @(posedge ref_clk) disable iff (rst_any)
    go && state == S_MAIN && idx == 3'h1 && op == OP_READ |-> go_byte == OPC_FAST_READ)
    else $error("fast read opcode wrong");

  read_dummy_a: assert property (
    @(posedge ref_clk) disable iff (rst_any)
    go && state == S_MAIN && idx == 3'h5 && op == OP_READ |-> go_byte == OPC_FILL)
    else $error("dummy byte missing");

  enable_byte_a: assert property (
    @(posedge ref_clk) disable iff (rst_any)
    go && state == S_ENABLE |-> go_byte == OPC_WRITE_ENABLE && !flash_select_low)
    else $error("write enable byte wrong");

  status_len_a: assert property (
    @(posedge ref_clk) disable iff (rst_any)
    go && state == S_MAIN && op == OP_STATUS_WRITE |-> idx <= 3'h1 || rem == '0)
    else $error("status write too long");

  latch_before_cmd_a: assert property (
    @(posedge ref_clk) disable iff (rst_any)
    go && state == S_MAIN && idx == 3'h1 && sfas_needs_enable(op) |-> latch_seen)
    else $error("command before latch set");

  port_float_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    !system_reset_low |=> !serial_port_clock_oe && !serial_port_data_oe && !flash_select_oe)
    else $error("port driven during reset");

  driver_sel_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    !system_reset_low |=> driver_select_low)
    else $error("driver select not held high");

  one_select_a: assert property (
    @(posedge ref_clk) disable iff (rst_any)
    !(!flash_select_low && !driver_select_low))
    else $error("both selects active");

  clock_idle_a: assert property (
    @(posedge ref_clk) disable iff (rst_any)
    flash_select_low && driver_select_low |-> !serial_port_clock_out)
    else $error("clock not idle low");

  deselect_gap_a: assert property (
    @(posedge ref_clk) disable iff (rst_any)
    $rose(flash_select_low) |-> flash_select_low [*8])
    else $error("select gap too short");

  divisor_range_a: assert property (
    @(posedge ref_clk) disable iff (rst_any)
    state != S_IDLE |-> div_q >= DIV_MIN && div_q <= DIV_MAX)
    else $error("divisor out of range");

endmodule

/* bench/sfas_flash_model.sv */
// behavioural serial flash and illumination driver on the far side
`timescale 1ns/1ps
module sfas_flash_model
  import sfas_pkg::*;
#(
  parameter int LATCH_LAG = 2
) (
  input wire logic serial_port_clock_out,
  input wire logic serial_port_data_out,
  input wire logic flash_select_low,
  input wire logic driver_select_low,
  output logic serial_port_data_in
);
  // ----
  // state
  // ----
  logic [7:0] mem [0:255];
  logic [7:0] status, opc, sh, ob, dsh;
  logic [23:0] addr, addr_seen;
  logic [63:0] op_hist, len_hist, drv_hist;
  logic latch_set;
  // hold input kept high by pull-up
  logic flash_hold_low;
  int bitc, bytec, polls, dbits;

  initial begin
    status = 8'h00;
    latch_set = 1'b0;
    flash_hold_low = 1'b1;
    serial_port_data_in = 1'b1;
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
  end

  task automatic take_byte(input logic [7:0] b);
    if (bytec == 0) opc = b;
    case (opc)
      // write enable sets latch, status read polls it late
      OPC_WRITE_ENABLE: begin
        latch_set = 1'b1;
        polls = 0;
      end
      OPC_STATUS_READ: begin
        if (bytec == 0) polls++;
        ob = {status[7:2], latch_set && (polls > LATCH_LAG), 1'b0};
      end
      OPC_STATUS_WRITE: if (bytec == 1 && latch_set) status = {b[7:2], 2'b00};
      // address msb first, bursts run while selected
      OPC_FAST_READ, OPC_PAGE_PROG, OPC_SECT_ERASE: begin
        if (bytec >= 1 && bytec <= 3) addr = {addr[15:0], b};
        if (bytec == 3) addr_seen = {addr[23:8], b};
        if (opc == OPC_PAGE_PROG && bytec >= 4 && latch_set) begin
          mem[addr[7:0]] = b;
          addr++;
        end
        if (opc == OPC_FAST_READ && bytec >= 4) begin
          ob = mem[addr[7:0]];
          addr++;
        end
      end
      default: ;
    endcase
  endtask

  // mode 0: capture on rising, shift out on falling
  always @(negedge flash_select_low) begin
    bitc = 0;
    bytec = 0;
    ob = 8'h00;
  end
  always @(posedge serial_port_clock_out) begin
    if (!flash_select_low && flash_hold_low) begin
      sh = {sh[6:0], serial_port_data_out};
      bitc++;
      if (bitc == 8) begin
        take_byte(sh);
        bytec++;
        bitc = 0;
      end
    end
    // illumination driver listens on its own select
    if (!driver_select_low) begin
      dsh = {dsh[6:0], serial_port_data_out};
      dbits++;
      if (dbits == 8) begin
        drv_hist = {drv_hist[55:0], dsh};
        dbits = 0;
      end
    end
  end
  always @(negedge driver_select_low) dbits = 0;
  always @(negedge serial_port_clock_out) begin
    if (!flash_select_low) serial_port_data_in = ob[7-bitc];
  end
  // each select ends one command, sector or chip erase fills all 256 bytes of the model memory
  always @(posedge flash_select_low) begin
    if (bytec > 0) begin
      op_hist = {op_hist[55:0], opc};
      len_hist = {len_hist[55:0], 8'(bytec)};
      if (latch_set && ((opc == OPC_SECT_ERASE && bytec == 4) ||
                  (opc == OPC_CHIP_ERASE && bytec == 1))) begin
        for (int i = 0; i < 256; i++) mem[i] = 8'hff;
      end
      if (opc != OPC_WRITE_ENABLE && opc != OPC_STATUS_READ) latch_set = 1'b0;
    end
    serial_port_data_in = ~serial_port_data_in;
  end
endmodule

/* bench/sfas_sequencer_bench.sv */
// self-checking bench of the serial flash access sequencer
`timescale 1ns/1ps
module sfas_sequencer_bench
  import sfas_pkg::*;
;
  // ----
  // signals
  // ----
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic system_reset_low = 1'b1;
  logic [DIV_W-1:0] clock_divisor = 7'h05;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [ADDR_W-1:0] cmd_addr = 24'h000000;
  logic [LEN_W-1:0] cmd_len = 16'h0000;
  logic [7:0] cmd_status = 8'h00;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic cmd_ready, wr_ready, rd_valid, done, sck, sck_oe, sdo, sdo_oe, sdi;
  logic fsel, fsel_oe, dsel;
  logic [7:0] rd_data;
  logic [7:0] rd_q [$];
  int n_fail = 0;
  int num_checks = 0;

  always #5 ref_clk = ~ref_clk;

  sfas_sequencer DUT (.ref_clk(ref_clk), .reset(reset), .system_reset_low(system_reset_low),
    .clock_divisor(clock_divisor), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_status(cmd_status),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .done(done), .serial_port_clock_out(sck),
    .serial_port_clock_oe(sck_oe), .serial_port_data_out(sdo), .serial_port_data_oe(sdo_oe),
    .serial_port_data_in(sdi), .flash_select_low(fsel), .flash_select_oe(fsel_oe),
    .driver_select_low(dsel));

  sfas_flash_model fm (.serial_port_clock_out(sck), .serial_port_data_out(sdo),
    .flash_select_low(fsel), .driver_select_low(dsel), .serial_port_data_in(sdi));

  // ----
  // shared tasks
  // ----
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic clear_log();
    fm.op_hist = 64'h0;
    fm.len_hist = 64'h0;
    fm.drv_hist = 64'h0;
  endtask

  task automatic run_cmd(input sfas_op_e op, input logic [23:0] a, input logic [15:0] n,
                         input logic [7:0] st);
    int k;
    rd_q.delete();
    @(negedge ref_clk);
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_len = n;
    cmd_status = st;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 40000) begin
      @(posedge ref_clk);
      #1;
      if (rd_valid === 1'b1) rd_q.push_back(rd_data);
      k++;
    end
    check("done", {63'h0, done}, 64'h1);
  endtask

  task automatic push_byte(input logic [7:0] b);
    @(negedge ref_clk);
    while (wr_ready !== 1'b1) @(negedge ref_clk);
    wr_valid = 1'b1;
    wr_data = b;
    @(negedge ref_clk);
    wr_valid = 1'b0;
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    @(negedge ref_clk);
    system_reset_low = 1'b0;
    repeat (4) @(negedge ref_clk);
    check("float_oe", {61'h0, sck_oe, sdo_oe, fsel_oe}, 64'h0);
    check("drv_sel_rst", {63'h0, dsel}, 64'h1);
    system_reset_low = 1'b1;
    repeat (4) @(negedge ref_clk);
    check("drive_oe", {61'h0, sck_oe, sdo_oe, fsel_oe}, 64'h7);
    check("idle_lines", {62'h0, sck, fsel}, 64'h1);
  endtask

  task automatic t_status();
    clear_log();
    run_cmd(OP_STATUS_WRITE, 24'h0, 16'h0, 8'h3c);
    check("status_write_ops", fm.op_hist, 64'h0605050501);
    check("status_write_lens", fm.len_hist, 64'h0102020202);
    run_cmd(OP_STATUS_READ, 24'h0, 16'h0, 8'h00);
    check("status_read_op", fm.op_hist[7:0], 64'h05);
    check("status_read_val", rd_q[0], 64'h3c);
  endtask

  task automatic t_program();
    clear_log();
    for (int i = 0; i < 16; i++) push_byte(8'h40 + 8'(i));
    @(negedge ref_clk);
    check("fifo_full", {63'h0, wr_ready}, 64'h0);
    run_cmd(OP_PROG, 24'h0a0b20, 16'h0010, 8'h00);
    check("prog_ops", fm.op_hist, 64'h0605050502);
    check("prog_lens", fm.len_hist, 64'h0102020214);
    check("prog_addr", fm.addr_seen, 64'h0a0b20);
    check("fifo_empty", {63'h0, wr_ready}, 64'h1);
    clear_log();
    run_cmd(OP_READ, 24'h0a0b20, 16'h0010, 8'h00);
    check("read_frame", {fm.op_hist[15:0], fm.len_hist[15:0]}, 64'h000b0015);
    check("read_count", rd_q.size(), 64'h10);
    for (int i = 0; i < 16; i++) check("read_data", rd_q[i], 64'h40 + 64'(i));
  endtask

  task automatic t_erase();
    clear_log();
    run_cmd(OP_SECT_ERASE, 24'h0a0b00, 16'h0, 8'h00);
    check("sect_ops", fm.op_hist, 64'h0605050520);
    check("sect_lens", fm.len_hist, 64'h0102020204);
    run_cmd(OP_READ, 24'h0a0b20, 16'h0001, 8'h00);
    check("erased", rd_q[0], 64'hff);
    clear_log();
    run_cmd(OP_CHIP_ERASE, 24'h0, 16'h0, 8'h00);
    check("chip_ops", fm.op_hist, 64'h06050505c7);
    check("chip_lens", fm.len_hist, 64'h0102020201);
  endtask

  task automatic t_driver();
    clear_log();
    @(negedge ref_clk);
    clock_divisor = 7'h07;
    push_byte(8'ha5);
    push_byte(8'h3c);
    run_cmd(OP_DRV_WRITE, 24'h0, 16'h0002, 8'h00);
    check("drv_bytes", fm.drv_hist, 64'ha53c);
    check("flash_quiet", fm.op_hist, 64'h0);
    check("clk_idle", {63'h0, sck}, 64'h0);
  endtask

  initial begin
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    t_reset();
    t_status();
    t_program();
    t_erase();
    t_driver();
    final_report();
  end

  initial begin
    #500000;
    n_fail++;
    final_report();
  end
endmodule
